/* rtl/hsd_pkg.sv */
/*
 * constants for the host serial port and converter command interpreter:
 * frame values, reply bytes, baud rates, register offsets, reset values.
 * assumes a single 100 MHz clock domain and 8N1 framing on the link.
 */
package hsd_pkg;
    // ------------------------------------------------------------------
    // message framing
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_LEN      = 8'h02; // converter command length
    localparam logic [7:0] CMD_ID       = 8'hE4; // converter command identifier
    localparam logic [7:0] CMD_SUB      = 8'h01; // first payload byte
    localparam logic [7:0] CONV_OFF     = 8'h00; // disable value
    localparam logic [7:0] CONV_ON      = 8'h01; // enable value
    localparam logic [7:0] RPL_LEN      = 8'h04; // reply length
    localparam logic [7:0] RPL_ID       = 8'hE0; // reply identifier
    localparam logic [7:0] RPL_B0       = 8'h00; // reply payload byte 0
    localparam logic [7:0] RES_OK       = 8'h00; // converter configured
    localparam logic [7:0] RES_FAIL     = 8'h01; // anything non-zero fails
    localparam logic [2:0] RPL_LAST     = 3'h7;  // index of reply checksum byte
    // ------------------------------------------------------------------
    // baud rates selectable by the rate pins
    // ------------------------------------------------------------------
    localparam int BAUD_2400   = 2400;
    localparam int BAUD_4800   = 4800;
    localparam int BAUD_9600   = 9600;
    localparam int BAUD_19200  = 19200;
    localparam int BAUD_38400  = 38400;
    localparam int BAUD_57600  = 57600;
    localparam int BAUD_115200 = 115200;
    localparam int CLK_HZ_DEF  = 100000000; // clock rate
    // ------------------------------------------------------------------
    // register map and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0; // live state, read only
    localparam logic [3:0] REG_CONFIG = 4'h4; // bit0 converter fitted
    localparam logic [3:0] REG_COUNT  = 4'h8; // accepted / checksum failure counts
    localparam logic [3:0] REG_RESULT = 4'hC; // last result byte
    localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
    localparam logic [7:0]  RST_RESULT = 8'h00;
    // parser states
    typedef enum logic [2:0] {
        ST_SYNC  = 3'b000,
        ST_LEN   = 3'b001,
        ST_ID    = 3'b010,
        ST_DATA  = 3'b011,
        ST_CHK   = 3'b100,
        ST_PROC  = 3'b101,
        ST_REPLY = 3'b110
    } hsd_state_t;
endpackage : hsd_pkg

/* rtl/hsd_top.sv */
/*
 * module side of the host serial link: rate pins, flow control,
 * converter configuration command with its fixed reply, updater strap.
 * assumes the host keeps to 8N1 at the rate its pins select.
 */
// Added by the designer: the strobed register port and the register addresses.
// Behaviour
// - RTS follows flow control, held high while processing
// - accept converter command, length 02 id E4
// - reply length 04 id E0, 00 E4 01 result
// - result zero means success, else failure
// - updater pin at reset release selects updater
// - updater mode adds host driven clear to send
`timescale 1ns/100ps
module hsd_top
    import hsd_pkg::*;
#(
    parameter int         CLK_HZ    = CLK_HZ_DEF, // lower in simulation for short bits
    parameter logic [7:0] SYNC_BYTE = 8'hA4       // leading sync value
) (
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        MODULE_SERIAL_IN,
    output logic             MODULE_SERIAL_OUT,
    input  wire logic        RATE_SELECT_LOW,
    input  wire logic        RATE_SELECT_MID,
    input  wire logic        RATE_SELECT_HIGH,
    output logic             RTS_N,
    input  wire logic        CTS_N,
    input  wire logic        UPDATER_ENTRY,
    output logic             UPDATER_MODE,
    output logic             CONVERTER_ENABLE,
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA
);
    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [5:0] meta_r;  // first stage, read only by second stage
    logic [5:0] sync_r;  // {boot, cts_n, high, mid, low, rx}

    // two flops on every pin before any logic sees it
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            meta_r <= 6'h21;
            sync_r <= 6'h21;
        end else begin
            meta_r <= {UPDATER_ENTRY, CTS_N, RATE_SELECT_HIGH,
                       RATE_SELECT_MID, RATE_SELECT_LOW, MODULE_SERIAL_IN};
            sync_r <= meta_r;
        end
    end

    // ------------------------------------------------------------------
    // rate decode
    // ------------------------------------------------------------------
    // pins only need to hold a level; any code is legal
    function automatic logic [15:0] rate_div(input logic [2:0] code);
        case (code) // {high, mid, low}
            3'b110:  rate_div = 16'(CLK_HZ / BAUD_2400);
            3'b000:  rate_div = 16'(CLK_HZ / BAUD_4800);
            3'b101:  rate_div = 16'(CLK_HZ / BAUD_9600);
            3'b010:  rate_div = 16'(CLK_HZ / BAUD_19200);
            3'b001:  rate_div = 16'(CLK_HZ / BAUD_38400);
            3'b100:  rate_div = 16'(CLK_HZ / BAUD_115200);
            default: rate_div = 16'(CLK_HZ / BAUD_57600);
        endcase
    endfunction : rate_div

    logic [15:0] div_r;  // clocks per bit

    // limitation: moving the pins mid-byte corrupts that byte
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) div_r <= 16'h0001;
        else         div_r <= rate_div(sync_r[3:1]);
    end

    // ------------------------------------------------------------------
    // updater strap
    // ------------------------------------------------------------------
    logic       captured_r;  // strap already taken
    logic [1:0] settle_r;    // edges since release, pin reaches sync_r at two

    // taken once, at the first edge synchronised data is valid after release
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            captured_r   <= 1'b0;
            settle_r     <= 2'h0;
            UPDATER_MODE <= 1'b0;
        end else if (settle_r != 2'h2) begin
            settle_r <= settle_r + 2'h1; // sync_r still shows its reset value
        end else if (!captured_r) begin
            captured_r   <= 1'b1;
            UPDATER_MODE <= sync_r[5];
        end
    end

    // ------------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------------
    logic       rx_valid;  // byte received
    logic [7:0] rx_byte;   // its value
    logic       tx_busy;   // transmitter occupied
    logic       tx_go;     // launch next reply byte
    logic [7:0] tx_byte;   // reply byte

    hsd_uart u_uart (
        .clk      (CLK),
        .rst_n    (RESETN),
        .div      (div_r),
        .rx_s     (sync_r[0]),
        .tx_go    (tx_go),
        .tx_byte  (tx_byte),
        .rx_valid (rx_valid),
        .rx_byte  (rx_byte),
        .tx_busy  (tx_busy),
        .tx_out   (MODULE_SERIAL_OUT)
    );

    // ------------------------------------------------------------------
    // frame parser
    // ------------------------------------------------------------------
    hsd_state_t state_r;    // parser state
    logic [7:0] len_r;      // payload length
    logic [7:0] id_r;       // message identifier
    logic [7:0] cnt_r;      // payload bytes taken
    logic [7:0] p0_r;       // payload byte 0
    logic [7:0] p1_r;       // payload byte 1
    logic [7:0] chk_r;      // running xor checksum
    logic [2:0] idx_r;      // reply byte index
    logic [7:0] result_r;   // last result byte
    logic       fitted_r;   // converter fitted, from software
    logic       is_cmd;     // frame is the converter command
    logic       chk_ok;     // checksum byte matches
    logic       accept;     // command taken
    logic       cts_hold;   // host blocks our transmit

    assign is_cmd   = (len_r == CMD_LEN) && (id_r == CMD_ID);
    assign chk_ok   = (rx_byte == chk_r);
    assign accept   = (state_r == ST_CHK) && rx_valid && chk_ok && is_cmd;
    assign cts_hold = UPDATER_MODE && sync_r[4];
    assign tx_go    = (state_r == ST_REPLY) && !tx_busy && !cts_hold;

    // reply byte table, checksum runs over everything before it
    always_comb begin
        case (idx_r)
            3'h0:    tx_byte = SYNC_BYTE;
            3'h1:    tx_byte = RPL_LEN;
            3'h2:    tx_byte = RPL_ID;
            3'h3:    tx_byte = RPL_B0;
            3'h4:    tx_byte = CMD_ID;
            3'h5:    tx_byte = CMD_SUB;
            3'h6:    tx_byte = result_r;
            default: tx_byte = chk_r;
        endcase
    end

    // one byte per pulse; frames of other identifiers pass silently
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_r <= ST_SYNC;
            len_r   <= 8'h00;
            id_r    <= 8'h00;
            cnt_r   <= 8'h00;
            p0_r    <= 8'h00;
            p1_r    <= 8'h00;
            chk_r   <= 8'h00;
            idx_r   <= 3'h0;
        end else begin
            case (state_r)
                ST_SYNC: if (rx_valid && rx_byte == SYNC_BYTE) begin
                    state_r <= ST_LEN;
                    chk_r   <= rx_byte;
                end
                ST_LEN: if (rx_valid) begin
                    len_r   <= rx_byte;
                    chk_r   <= chk_r ^ rx_byte;
                    state_r <= ST_ID;
                end
                ST_ID: if (rx_valid) begin
                    id_r    <= rx_byte;
                    chk_r   <= chk_r ^ rx_byte;
                    cnt_r   <= 8'h00;
                    state_r <= (len_r == 8'h00) ? ST_CHK : ST_DATA;
                end
                ST_DATA: if (rx_valid) begin
                    chk_r <= chk_r ^ rx_byte;
                    cnt_r <= cnt_r + 8'h01;
                    if (cnt_r == 8'h00) p0_r <= rx_byte;
                    if (cnt_r == 8'h01) p1_r <= rx_byte;
                    if (cnt_r == len_r - 8'h01) state_r <= ST_CHK;
                end
                ST_CHK: if (rx_valid) begin
                    state_r <= accept ? ST_PROC : ST_SYNC;
                end
                ST_PROC: begin // result settles here, reply starts next
                    state_r <= ST_REPLY;
                    idx_r   <= 3'h0;
                    chk_r   <= 8'h00;
                end
                ST_REPLY: if (tx_go) begin
                    chk_r <= chk_r ^ tx_byte;
                    idx_r <= idx_r + 3'h1;
                    if (idx_r == RPL_LAST) state_r <= ST_SYNC;
                end
                default: state_r <= ST_SYNC;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // converter control and result
    // ------------------------------------------------------------------
    // failure when the value is unknown or enabling an absent converter
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            CONVERTER_ENABLE <= 1'b0;
            result_r         <= RST_RESULT;
        end else if (accept) begin
            if (p0_r == CMD_SUB && (p1_r == CONV_OFF || (p1_r == CONV_ON && fitted_r))) begin
                CONVERTER_ENABLE <= p1_r[0];
                result_r         <= RES_OK;
            end else begin
                result_r <= RES_FAIL;
            end
        end
    end

    // ------------------------------------------------------------------
    // flow control
    // ------------------------------------------------------------------
    // not ready while a message is worked on; host paces bytes on this
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) RTS_N <= 1'b1;
        else         RTS_N <= !captured_r || state_r == ST_PROC || state_r == ST_REPLY;
    end

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    logic [7:0] n_acc_r;  // commands accepted
    logic [7:0] n_bad_r;  // checksum failures

    // software writes the fitted flag; counters wrap
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            fitted_r <= RST_CONFIG[0];
            n_acc_r  <= 8'h00;
            n_bad_r  <= 8'h00;
        end else begin
            if (WR && ADDR == REG_CONFIG) fitted_r <= WDATA[0];
            if (accept) n_acc_r <= n_acc_r + 8'h01;
            if (state_r == ST_CHK && rx_valid && !chk_ok) n_bad_r <= n_bad_r + 8'h01;
        end
    end

    // read data only in the cycle after the strobe, zero elsewhere
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) RDATA <= 32'h0000_0000;
        else if (!RD) RDATA <= 32'h0000_0000;
        else begin
            case (ADDR)
                REG_STATUS: RDATA <= {25'h0, sync_r[3:1], RTS_N, sync_r[4],
                                      UPDATER_MODE, CONVERTER_ENABLE};
                REG_CONFIG: RDATA <= {31'h0, fitted_r};
                REG_COUNT:  RDATA <= {16'h0, n_bad_r, n_acc_r};
                REG_RESULT: RDATA <= {24'h0, result_r};
                default:    RDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_RTS_BUSY: assert property (@(posedge CLK) disable iff (!RESETN)
        accept |=> ##1 RTS_N [*2]) else $error("rts not held during processing");
    AST_CONV_SET: assert property (@(posedge CLK) disable iff (!RESETN)
        (accept && p0_r == CMD_SUB && p1_r == CONV_OFF) |=> !CONVERTER_ENABLE)
        else $error("converter not disabled");
    AST_REPLY_HDR: assert property (@(posedge CLK) disable iff (!RESETN)
        (tx_go && idx_r == 3'h1) |-> tx_byte == RPL_LEN && $past(state_r, 1) == ST_REPLY)
        else $error("reply length wrong");
    AST_RESULT: assert property (@(posedge CLK) disable iff (!RESETN)
        (accept && p1_r > CONV_ON) |=> result_r != RES_OK) else $error("bad value passed");
    AST_STRAP: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(captured_r) |-> UPDATER_MODE == $past(sync_r[5])) else $error("strap lost");
    AST_CTS_GATE: assert property (@(posedge CLK) disable iff (!RESETN)
        (UPDATER_MODE && sync_r[4] && !tx_busy) |=> !tx_busy) else $error("sent against cts");
    AST_SYNC_LEAD: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(state_r == ST_REPLY) |-> ##[0:2] (tx_go && tx_byte == SYNC_BYTE)
        or sync_r[4]) else $error("reply without sync");
    AST_BAD_CHK: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_r == ST_CHK && rx_valid && !chk_ok) |=> state_r == ST_SYNC)
        else $error("bad checksum answered");
endmodule : hsd_top

/* rtl/hsd_uart.sv */
/*
 * 8N1 receiver and transmitter with a run-time bit divisor.
 * assumes rx_s is already synchronised to clk; tx_go only while idle.
 */
`timescale 1ns/100ps
module hsd_uart (
    input  wire logic        clk,      // system clock
    input  wire logic        rst_n,    // async reset, active low
    input  wire logic [15:0] div,      // clocks per bit
    input  wire logic        rx_s,     // synchronised serial input
    input  wire logic        tx_go,    // start a byte
    input  wire logic [7:0]  tx_byte,  // byte to send
    output logic             rx_valid, // one-cycle byte pulse
    output logic [7:0]       rx_byte,  // received byte
    output logic             tx_busy,  // transmitter occupied
    output logic             tx_out    // serial output, from a flop
);
    // ------------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------------
    logic [15:0] rcnt_r;   // bit timer
    logic [3:0]  rbit_r;   // bit index, 0 = start
    logic        ract_r;   // frame in progress
    logic [7:0]  rsh_r;    // shift register

    // sample in mid-bit; a false start is dropped at its centre
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_r   <= 16'h0000;
            rbit_r   <= 4'h0;
            ract_r   <= 1'b0;
            rsh_r    <= 8'h00;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (!ract_r) begin
                if (!rx_s) begin // start edge
                    ract_r <= 1'b1;
                    rbit_r <= 4'h0;
                    rcnt_r <= {1'b0, div[15:1]};
                end
            end else if (rcnt_r != 16'h0000) begin
                rcnt_r <= rcnt_r - 16'h0001;
            end else begin
                rcnt_r <= div - 16'h0001;
                rbit_r <= rbit_r + 4'h1;
                if (rbit_r == 4'h0 && rx_s) begin
                    ract_r <= 1'b0; // glitch, not a start bit
                end else if (rbit_r == 4'h9) begin
                    ract_r   <= 1'b0;
                    rx_valid <= rx_s; // bad stop bit drops the byte
                    rx_byte  <= rsh_r;
                end else if (rbit_r != 4'h0) begin
                    rsh_r <= {rx_s, rsh_r[7:1]};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    logic [15:0] tcnt_r;   // bit timer
    logic [3:0]  tbit_r;   // bits left
    logic [8:0]  tsh_r;    // data plus stop bit

    // lsb first, start bit driven straight away
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tcnt_r  <= 16'h0000;
            tbit_r  <= 4'h0;
            tsh_r   <= 9'h1FF;
            tx_out  <= 1'b1;
            tx_busy <= 1'b0;
        end else if (!tx_busy) begin
            if (tx_go) begin
                tx_busy <= 1'b1;
                tx_out  <= 1'b0;
                tsh_r   <= {1'b1, tx_byte};
                tbit_r  <= 4'h9;
                tcnt_r  <= div - 16'h0001;
            end
        end else if (tcnt_r != 16'h0000) begin
            tcnt_r <= tcnt_r - 16'h0001;
        end else if (tbit_r == 4'h0) begin
            tx_busy <= 1'b0; // stop bit done
        end else begin
            tx_out <= tsh_r[0];
            tsh_r  <= {1'b1, tsh_r[8:1]};
            tbit_r <= tbit_r - 4'h1;
            tcnt_r <= div - 16'h0001;
        end
    end
endmodule : hsd_uart

/* tb/hsd_host_model.sv */
/*
 * behavioural host microcontroller: 8N1 sender with per-byte flow control,
 * listener that queues bytes from the module, clear-to-send driver.
 * assumes one clock shared with the module and DIV clocks per bit.
 */
`timescale 1ns/100ps
module hsd_host_model #(
    parameter int DIV = 8 // clocks per serial bit
) (
    input  wire logic clk,      // shared clock
    input  wire logic rst_n,    // module reset, active low
    input  wire logic from_mod, // module serial output, wired straight in
    output logic      to_mod,   // our transmit line, idle high
    input  wire logic rts_n,    // module request to send
    output logic      cts_n     // our clear to send
);
    logic [7:0] rx_q[$];  // bytes heard from the module
    int         busy_cnt; // busy phases seen on rts_n
    logic       rts_q;    // rts_n one clock back
    logic [7:0] b;        // byte being assembled
    int         i;        // bit index of listener
    int         stalls;   // per-byte polls that ran out

    initial begin
        to_mod   = 1'b1;
        cts_n    = 1'b0;
        busy_cnt = 0;
        stalls   = 0;
    end

    // --------------------------------------------------------------
    // count each rise of rts_n after reset settles
    // --------------------------------------------------------------
    always @(posedge clk) begin
        if (rst_n && rts_q === 1'b0 && rts_n === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end
        rts_q <= rts_n;
    end

    // --------------------------------------------------------------
    // listener: mid-bit sampling, lsb first
    // --------------------------------------------------------------
    always begin
        @(negedge from_mod);
        repeat (DIV / 2) @(posedge clk);
        for (i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge clk);
            b[i] = from_mod;
        end
        repeat (DIV) @(posedge clk);
        rx_q.push_back(b);
    end

    // one byte; no flow control in hardware, so rts_n is polled per byte
    task send_byte(input logic [7:0] d);
        int         k;
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        @(posedge clk);
        for (k = 0; k < 2000 && rts_n !== 1'b0; k++) @(posedge clk);
        if (rts_n !== 1'b0) stalls++;
        for (k = 0; k < 10; k++) begin
            to_mod <= f[k];
            repeat (DIV) @(posedge clk);
        end
    endtask : send_byte

    // clear to send is a plain level toward the module
    task set_cts(input logic v);
        @(posedge clk);
        cts_n <= v;
    endtask : set_cts
endmodule : hsd_host_model

/* tb/tb_top.sv */
/*
 * self-checking bench: reset, rate pins, converter command and reply,
 * bad checksum, updater strap with clear to send.
 * assumes CLK_HZ of 1 MHz so 115200 baud gives 8 clocks per bit.
 */
`timescale 1ns/100ps
module tb_top;
    import hsd_pkg::*;
    localparam logic [7:0] SYNC = 8'hA4; // sync value for this run
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [2:0]  rate = 3'h4;       // {high,mid,low}, 115200
    logic        strap = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata, d;
    logic        ser_in, ser_out, rts_n, cts_n, upd, conv;
    int          n_errors = 0;
    int          compares = 0;

    always #5 clk = ~clk;

    hsd_top #(.CLK_HZ(1000000), .SYNC_BYTE(SYNC)) uut (
        .CLK(clk), .RESETN(resetn), .MODULE_SERIAL_IN(ser_in),
        .MODULE_SERIAL_OUT(ser_out), .RATE_SELECT_LOW(rate[0]),
        .RATE_SELECT_MID(rate[1]), .RATE_SELECT_HIGH(rate[2]), .RTS_N(rts_n),
        .CTS_N(cts_n), .UPDATER_ENTRY(strap), .UPDATER_MODE(upd),
        .CONVERTER_ENABLE(conv), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata));
    hsd_host_model #(.DIV(8)) host (
        .clk(clk), .rst_n(resetn), .from_mod(ser_out), .to_mod(ser_in),
        .rts_n(rts_n), .cts_n(cts_n));

    // --------------------------------------------------------------
    // shared helpers
    // --------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task tally_and_finish;
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
        @(posedge clk) wr <= 1'b0;
    endtask : reg_wr

    // read data stand only in the cycle after the strobe
    task reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk) begin addr <= a; rd <= 1'b1; end
        @(posedge clk) rd <= 1'b0;
        #1 v = rdata;
    endtask : reg_rd

    // strap held well past the capture edge
    task do_reset(input logic s);
        @(posedge clk) begin resetn <= 1'b0; strap <= s; end
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
    endtask : do_reset

    task send_cmd(input logic [7:0] v, input logic [7:0] spoil);
        logic [7:0] f[6];
        int         k;
        f = '{SYNC, CMD_LEN, CMD_ID, CMD_SUB, v, 8'h00};
        f[5] = SYNC ^ CMD_LEN ^ CMD_ID ^ CMD_SUB ^ v ^ spoil;
        for (k = 0; k < 6; k++) host.send_byte(f[k]);
    endtask : send_cmd

    task expect_reply(input logic [7:0] res);
        logic [7:0] e[8];
        int         k;
        e = '{SYNC, RPL_LEN, RPL_ID, 8'h00, 8'hE4, 8'h01, res, 8'h00};
        e[7] = SYNC ^ RPL_LEN ^ RPL_ID ^ 8'hE4 ^ 8'h01 ^ res;
        for (k = 0; k < 3000 && host.rx_q.size() < 8; k++) @(posedge clk);
        check(host.rx_q.size(), 8);
        for (k = 0; k < 8 && k < host.rx_q.size(); k++) check(host.rx_q[k], e[k]);
        host.rx_q.delete();
    endtask : expect_reply

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task t_reset;
        check({rts_n, upd, conv, ser_out}, 4'h1);
        reg_wr(4'h2, 32'hFFFF_FFFF);
        reg_rd(4'h2, d);
        check(d, 32'h0);
        reg_rd(REG_CONFIG, d);
        check(d, RST_CONFIG);
    endtask : t_reset

    task t_rates;
        int k;
        for (k = 0; k < 8; k++) begin
            @(posedge clk) rate <= k[2:0];
            repeat (4) @(posedge clk);
            reg_rd(REG_STATUS, d);
            check(d[6:4], k[2:0]);
        end
        @(posedge clk) rate <= 3'h4;
        repeat (4) @(posedge clk);
    endtask : t_rates

    task t_convert;
        int b0;
        b0 = host.busy_cnt;
        reg_wr(REG_CONFIG, 32'h1);
        send_cmd(CONV_ON, 8'h00);
        expect_reply(RES_OK);
        check(conv, 1'b1);
        check(host.busy_cnt, b0 + 1);
        send_cmd(CONV_OFF, 8'h00);
        expect_reply(RES_OK);
        check(conv, 1'b0);
        reg_wr(REG_CONFIG, 32'h0);
        send_cmd(CONV_ON, 8'h00);
        expect_reply(RES_FAIL);
        check(conv, 1'b0);
        reg_rd(REG_RESULT, d);
        check(d[7:0], RES_FAIL);
        send_cmd(8'h02, 8'h00);
        expect_reply(RES_FAIL);
    endtask : t_convert

    task t_badsum;
        send_cmd(CONV_OFF, 8'h5A);
        repeat (1500) @(posedge clk);
        check(host.rx_q.size(), 0);
        reg_rd(REG_COUNT, d);
        check(d[15:0], 16'h0104);
    endtask : t_badsum

    task t_updater;
        host.set_cts(1'b1);
        do_reset(1'b1);
        check(upd, 1'b1);
        reg_rd(REG_STATUS, d);
        check(d[3:0], 4'h6);
        send_cmd(CONV_OFF, 8'h00);
        repeat (1500) @(posedge clk);
        check(host.rx_q.size(), 0);
        host.set_cts(1'b0);
        expect_reply(RES_OK);
        check(host.stalls, 0);
    endtask : t_updater

    initial begin
        do_reset(1'b0);
        t_reset();
        t_rates();
        t_convert();
        t_badsum();
        t_updater();
        tally_and_finish();
    end

    // watchdog well beyond the expected 10k cycles
    initial begin
        #500000;
        n_errors++;
        tally_and_finish();
    end
endmodule : tb_top
